// ===== core/route_bank_pkg.sv
package route_bank_pkg;

  // Register byte offsets.
  localparam logic [11:0] OFS_BOOT_REMAP = 12'h000;
  localparam logic [11:0] OFS_SELECT_0_3 = 12'h008;
  localparam logic [11:0] OFS_SELECT_4_7 = 12'h00c;
  localparam logic [11:0] OFS_SELECT_8_11 = 12'h010;
  localparam logic [11:0] OFS_SELECT_12_15 = 12'h014;
  localparam logic [11:0] OFS_FAULT_LOCK = 12'h018;
  localparam logic [11:0] OFS_EVENT_STATUS = 12'h020;
  localparam logic [11:0] OFS_EVENT_MASK = 12'h024;

  // Reset values.
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [1:0] RESET_BOOT = 2'h0;

  // Field positions in the boot and remap control register.
  localparam int unsigned BIT_HIGH_DRIVE = 19;
  localparam int unsigned BIT_THIRD_TIMER = 12;
  localparam int unsigned BIT_SECOND_TIMER = 11;
  localparam int unsigned BIT_SERIAL_RX = 10;
  localparam int unsigned BIT_SERIAL_TX = 9;
  localparam int unsigned BIT_CONVERTER = 8;
  localparam int unsigned BIT_PIN_PAIR = 4;
  localparam logic [31:0] REMAP_WRITE_MASK = 32'h0008_1f10;
  localparam logic [31:0] HIGH_DRIVE_MASK = 32'h0008_0000;
  localparam logic [31:0] SELECT_WRITE_MASK = 32'h0000_ffff;

  // Field positions in the fault lock register.
  localparam int unsigned BIT_PARITY_FLAG = 8;
  localparam int unsigned LOCK_LOW_VOLTAGE = 2;
  localparam int unsigned LOCK_PARITY = 1;
  localparam int unsigned LOCK_CORE_STALL = 0;
  localparam int unsigned LOCK_WIDTH = 3;

  // Event status bits, shared with the mask register.
  localparam int unsigned EV_PARITY = 0;
  localparam int unsigned EV_LOW_VOLTAGE = 1;
  localparam int unsigned EV_CORE_STALL = 2;
  localparam int unsigned EV_RESERVED_SELECT = 3;
  localparam int unsigned STATUS_WIDTH = 4;

  // The boot select pin is caught on this clock edge after reset release.
  localparam logic [2:0] BOOT_LATCH_EDGE = 3'h4;

  localparam int unsigned LINE_COUNT = 16;
  localparam int unsigned SELECT_WIDTH = 4;
  localparam int unsigned DMA_CHANNELS = 5;

  // Source codes; the top selector bit is a don't-care.
  localparam logic [2:0] CODE_PORT_A = 3'h0;
  localparam logic [2:0] CODE_PORT_B = 3'h1;
  localparam logic [2:0] CODE_PORT_C = 3'h2;
  localparam logic [2:0] CODE_PORT_F = 3'h5;

  // Line-specific availability of the sources.
  localparam int unsigned LINE_NO_PORT_B_SECOND = 9;
  localparam int unsigned LINE_PORT_C_FIRST_ONLY = 13;
  localparam logic [15:0] PORT_C_LINES = 16'hc000;
  localparam logic [15:0] PORT_F_LINES = 16'h00c3;

  // Tells whether a source code is assigned on a given line and variant.
  function automatic logic code_valid(input int unsigned line, input logic [2:0] code,
                                      input logic second_variant);
    logic ok;
    ok = 1'b0;
    case (code)
      CODE_PORT_A: ok = 1'b1;
      CODE_PORT_B: ok = !(second_variant && line == LINE_NO_PORT_B_SECOND);
      CODE_PORT_C: ok = PORT_C_LINES[line] ||
                        (!second_variant && line == LINE_PORT_C_FIRST_ONLY);
      CODE_PORT_F: ok = PORT_F_LINES[line];
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : code_valid

endpackage : route_bank_pkg

// ===== core/event_source_mux.sv
`timescale 1ns/100ps
module event_source_mux
  import route_bank_pkg::*;
#(
  parameter logic SECOND_VARIANT = 1'b0
) (
  // Selector codes, four bits per line.
  input wire logic [63:0] line_source_select,
  // Port pin levels.
  input wire logic [15:0] port_a_pins,
  input wire logic [15:0] port_b_pins,
  input wire logic [15:0] port_c_pins,
  input wire logic [15:0] port_f_pins,
  // Selected level per line, low for a reserved code.
  output logic [15:0] line_level
);

  for (genvar n = 0; n < LINE_COUNT; n++) begin : g_line
    logic [2:0] code;
    assign code = line_source_select[SELECT_WIDTH*n +: 3];
    always_comb begin
      line_level[n] = 1'b0;
      if (code_valid(n, code, SECOND_VARIANT)) begin // RULE_14
        case (code)
          CODE_PORT_A: line_level[n] = port_a_pins[n]; // RULE_11
          CODE_PORT_B: line_level[n] = port_b_pins[n]; // RULE_11
          CODE_PORT_C: line_level[n] = port_c_pins[n]; // RULE_13
          CODE_PORT_F: line_level[n] = port_f_pins[n]; // RULE_12
          default: line_level[n] = 1'b0;
        endcase
      end
    end
  end

endmodule : event_source_mux

// ===== core/dma_request_router.sv
`timescale 1ns/100ps
module dma_request_router
  import route_bank_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Route selects.
  input wire logic third_timer_dma_route,
  input wire logic second_timer_dma_route,
  input wire logic serial_rx_dma_route,
  input wire logic serial_tx_dma_route,
  input wire logic converter_dma_route,
  // Peripheral requests.
  input wire logic third_timer_ch1_req,
  input wire logic third_timer_update_req,
  input wire logic second_timer_ch1_req,
  input wire logic second_timer_update_req,
  input wire logic serial_rx_req,
  input wire logic serial_tx_req,
  input wire logic converter_req,
  // Requests per controller channel, registered.
  output logic [4:0] dma_channel_req
);

  logic [4:0] chan_next;
  logic third_any;
  logic second_any;

  assign third_any = third_timer_ch1_req | third_timer_update_req;
  assign second_any = second_timer_ch1_req | second_timer_update_req;

  always_comb begin
    chan_next = 5'h00;
    chan_next[third_timer_dma_route ? 1 : 0] = third_any; // RULE_02
    chan_next[second_timer_dma_route ? 3 : 2] |= second_any; // RULE_03
    chan_next[serial_rx_dma_route ? 4 : 2] |= serial_rx_req; // RULE_04
    chan_next[serial_tx_dma_route ? 3 : 1] |= serial_tx_req; // RULE_05
    chan_next[converter_dma_route ? 1 : 0] |= converter_req; // RULE_06
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_channel_req <= 5'h00;
    end else begin
      dma_channel_req <= chan_next; // RULE_19
    end
  end

  AST_THIRD_TIMER_ROUTE: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
    third_timer_ch1_req && !third_timer_dma_route |=> dma_channel_req[0])
    else $error("third timer request missed channel 0");

  AST_SERIAL_RX_ROUTE: assert property (@(posedge pclk) disable iff (!presetn) // RULE_04
    serial_rx_req && serial_rx_dma_route |=> dma_channel_req[4])
    else $error("serial receive request missed channel 4");

  AST_CONVERTER_ROUTE: assert property (@(posedge pclk) disable iff (!presetn) // RULE_06
    converter_req && converter_dma_route |=> dma_channel_req[1])
    else $error("converter request missed channel 1");

endmodule : dma_request_router

// ===== core/system_config_routing_bank.sv
// Notes on behaviour
// (RULE_01) Bit 19 enables high drive, bypasses speed.
// (RULE_02) Bit 12 moves third timer requests 0->1.
// (RULE_03) Bit 11 moves second timer requests 2->3.
// (RULE_04) Bit 10 moves serial receive request 2->4.
// (RULE_05) Bit 9 moves serial transmit request 1->3.
// (RULE_06) Bit 8 moves converter request 0->1.
// (RULE_07) Bit 4 swaps shared pin pair.
// (RULE_08) Bits 1:0 read latched boot source.
// (RULE_09) Boot code: x0 flash, 01 system, 11 SRAM.
// (RULE_10) First register resets zero except boot field.
// (RULE_11) Four-bit selector per line; A and B.
// (RULE_12) Port F code only on lines 0,1,6,7.
// (RULE_13) Port C code on 14,15; 13 first variant.
// (RULE_14) Other codes reserved; variant exceptions apply.
// (RULE_15) Fault lock register: flag bit 8, locks 2:0.
// (RULE_16) Parity failure sets flag; write one clears.
// (RULE_17) Lock bits set by software, reset-only clear.
// (RULE_18) Locks gate faults onto timer break.
// (RULE_19) Routing follows writes on next cycle.
`timescale 1ns/100ps
module system_config_routing_bank
  import route_bank_pkg::*;
#(
  parameter logic SECOND_VARIANT = 1'b0
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Boot straps.
  input wire logic boot_select_pin,
  input wire logic inverted_boot_option_bit,
  // Pin options.
  output logic high_drive_pin_enable,
  output logic pin_pair_swap,
  // Event line sources.
  input wire logic [15:0] port_a_pins,
  input wire logic [15:0] port_b_pins,
  input wire logic [15:0] port_c_pins,
  input wire logic [15:0] port_f_pins,
  output logic [15:0] event_lines,
  // DMA requests.
  input wire logic third_timer_ch1_req,
  input wire logic third_timer_update_req,
  input wire logic second_timer_ch1_req,
  input wire logic second_timer_update_req,
  input wire logic serial_rx_req,
  input wire logic serial_tx_req,
  input wire logic converter_req,
  output logic [4:0] dma_channel_req,
  // Fault sources and timer break.
  input wire logic parity_error_in,
  input wire logic low_voltage_event,
  input wire logic core_stall_in,
  output logic timer_break,
  // Interrupt.
  output logic irq
);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [31:0] remap_cfg_reg;
  logic [63:0] select_reg;
  logic [LOCK_WIDTH-1:0] lock_reg;
  logic parity_flag_reg;
  logic [1:0] boot_mode_reg;
  logic [2:0] boot_edge_reg;
  logic [STATUS_WIDTH-1:0] status_reg;
  logic [STATUS_WIDTH-1:0] mask_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic high_drive_reg;
  logic pin_pair_reg;
  logic [15:0] event_lines_reg;
  logic timer_break_reg;
  logic irq_reg;
  logic [15:0] line_level;
  logic [31:0] read_next;
  logic mapped;
  logic setup_phase;
  logic wr_en;
  logic [31:0] remap_view;
  logic [31:0] lock_view;
  logic [STATUS_WIDTH-1:0] event_set;
  logic reserved_write;

  // The bus answers in the first access cycle with no wait state.
  assign setup_phase = psel && !penable;
  assign wr_en = psel && penable && pwrite && pready_reg;

  // Bit 19 does not exist on the second variant and always reads zero there.
  assign remap_view = (remap_cfg_reg & (SECOND_VARIANT ? ~HIGH_DRIVE_MASK : 32'hffff_ffff))
                      | {30'h0000_0000, boot_mode_reg}; // RULE_10
  assign lock_view = {23'h00_0000, parity_flag_reg, 5'h00, lock_reg}; // RULE_15

  always_comb begin
    read_next = RESET_WORD;
    mapped = 1'b1;
    case (paddr)
      OFS_BOOT_REMAP: read_next = remap_view; // RULE_08
      OFS_SELECT_0_3: read_next = {16'h0000, select_reg[15:0]};
      OFS_SELECT_4_7: read_next = {16'h0000, select_reg[31:16]};
      OFS_SELECT_8_11: read_next = {16'h0000, select_reg[47:32]};
      OFS_SELECT_12_15: read_next = {16'h0000, select_reg[63:48]};
      OFS_FAULT_LOCK: read_next = lock_view;
      OFS_EVENT_STATUS: read_next = {28'h000_0000, status_reg};
      OFS_EVENT_MASK: read_next = {28'h000_0000, mask_reg};
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= RESET_WORD;
    end else begin
      pready_reg <= setup_phase;
      pslverr_reg <= setup_phase && !mapped;
      if (setup_phase) begin
        prdata_reg <= pwrite ? RESET_WORD : read_next;
      end
    end
  end

  // Boot and remap control; the boot field is read-only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remap_cfg_reg <= RESET_WORD; // RULE_10
    end else if (wr_en && paddr == OFS_BOOT_REMAP) begin
      remap_cfg_reg <= pwdata & REMAP_WRITE_MASK; // RULE_07
    end
  end

  // The boot select pin is caught on a fixed edge after reset release.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_edge_reg <= 3'h0;
      boot_mode_reg <= RESET_BOOT;
    end else if (boot_edge_reg != BOOT_LATCH_EDGE) begin
      boot_edge_reg <= boot_edge_reg + 3'h1;
      if (boot_edge_reg == BOOT_LATCH_EDGE - 3'h1) begin
        boot_mode_reg <= {!inverted_boot_option_bit, boot_select_pin}; // RULE_08 RULE_09
      end
    end
  end

  // Event line selectors, sixteen bits per register.
  for (genvar r = 0; r < 4; r++) begin : g_select
    localparam logic [11:0] OFS = OFS_SELECT_0_3 + 12'(4 * r);
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        select_reg[16*r +: 16] <= 16'h0000;
      end else if (wr_en && paddr == OFS) begin
        select_reg[16*r +: 16] <= pwdata[15:0]; // RULE_11
      end
    end
  end

  // Flags a selector write that holds any reserved code.
  always_comb begin
    reserved_write = 1'b0;
    for (int n = 0; n < LINE_COUNT; n++) begin
      if (wr_en && paddr == OFS_SELECT_0_3 + 12'(4 * (n / 4)) &&
          !code_valid(n, pwdata[SELECT_WIDTH*(n%4) +: 3], SECOND_VARIANT)) begin
        reserved_write = 1'b1; // RULE_14
      end
    end
  end

  // Lock bits only ever set until reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_reg <= 3'h0; // RULE_15
    end else if (wr_en && paddr == OFS_FAULT_LOCK) begin
      lock_reg <= lock_reg | pwdata[LOCK_WIDTH-1:0]; // RULE_17
    end
  end

  // A parity failure in the clearing cycle keeps the flag set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      parity_flag_reg <= 1'b0;
    end else begin
      parity_flag_reg <= parity_error_in || (parity_flag_reg && // RULE_16
        !(wr_en && paddr == OFS_FAULT_LOCK && pwdata[BIT_PARITY_FLAG]));
    end
  end

  // Interrupt status, mask and output.
  always_comb begin
    event_set = '0;
    event_set[EV_PARITY] = parity_error_in;
    event_set[EV_LOW_VOLTAGE] = low_voltage_event;
    event_set[EV_CORE_STALL] = core_stall_in;
    event_set[EV_RESERVED_SELECT] = reserved_write;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= '0;
    end else if (wr_en && paddr == OFS_EVENT_STATUS) begin
      status_reg <= event_set | (status_reg & ~pwdata[STATUS_WIDTH-1:0]);
    end else begin
      status_reg <= status_reg | event_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= '0;
    end else if (wr_en && paddr == OFS_EVENT_MASK) begin
      mask_reg <= pwdata[STATUS_WIDTH-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(status_reg & mask_reg);
    end
  end

  // Pin options.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_drive_reg <= 1'b0;
      pin_pair_reg <= 1'b0;
    end else begin
      high_drive_reg <= remap_view[BIT_HIGH_DRIVE]; // RULE_01
      pin_pair_reg <= remap_cfg_reg[BIT_PIN_PAIR]; // RULE_07
    end
  end

  // Fault sources reach the break inputs only while their lock is set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_break_reg <= 1'b0;
    end else begin
      timer_break_reg <= (lock_reg[LOCK_PARITY] && parity_flag_reg) || // RULE_18
                         (lock_reg[LOCK_LOW_VOLTAGE] && low_voltage_event) ||
                         (lock_reg[LOCK_CORE_STALL] && core_stall_in);
    end
  end

  event_source_mux #(
    .SECOND_VARIANT(SECOND_VARIANT)
  ) u_mux (
    .line_source_select(select_reg),
    .port_a_pins(port_a_pins),
    .port_b_pins(port_b_pins),
    .port_c_pins(port_c_pins),
    .port_f_pins(port_f_pins),
    .line_level(line_level)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_lines_reg <= 16'h0000;
    end else begin
      event_lines_reg <= line_level; // RULE_19
    end
  end

  dma_request_router u_router (
    .pclk(pclk),
    .presetn(presetn),
    .third_timer_dma_route(remap_cfg_reg[BIT_THIRD_TIMER]),
    .second_timer_dma_route(remap_cfg_reg[BIT_SECOND_TIMER]),
    .serial_rx_dma_route(remap_cfg_reg[BIT_SERIAL_RX]),
    .serial_tx_dma_route(remap_cfg_reg[BIT_SERIAL_TX]),
    .converter_dma_route(remap_cfg_reg[BIT_CONVERTER]),
    .third_timer_ch1_req(third_timer_ch1_req),
    .third_timer_update_req(third_timer_update_req),
    .second_timer_ch1_req(second_timer_ch1_req),
    .second_timer_update_req(second_timer_update_req),
    .serial_rx_req(serial_rx_req),
    .serial_tx_req(serial_tx_req),
    .converter_req(converter_req),
    .dma_channel_req(dma_channel_req)
  );

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign high_drive_pin_enable = high_drive_reg;
  assign pin_pair_swap = pin_pair_reg;
  assign event_lines = event_lines_reg;
  assign timer_break = timer_break_reg;
  assign irq = irq_reg;

  AST_HIGH_DRIVE: assert property ( // RULE_01
    high_drive_pin_enable == ($past(remap_cfg_reg[BIT_HIGH_DRIVE]) && !SECOND_VARIANT))
    else $error("high drive does not follow bit 19");

  AST_BOOT_READ_ONLY: assert property ( // RULE_08
    wr_en && paddr == OFS_BOOT_REMAP && boot_edge_reg == BOOT_LATCH_EDGE
    |=> boot_mode_reg == $past(boot_mode_reg))
    else $error("bus write changed the boot field");

  AST_PORT_F_LINE0: assert property ( // RULE_12
    select_reg[2:0] == CODE_PORT_F |=> event_lines[0] == $past(port_f_pins[0]))
    else $error("line 0 does not follow port F");

  AST_RESERVED_LINE2: assert property ( // RULE_14
    select_reg[10:8] == CODE_PORT_F |=> !event_lines[2])
    else $error("reserved code on line 2 drove the line");

  AST_PARITY_SET: assert property ( // RULE_16
    parity_error_in |=> parity_flag_reg)
    else $error("parity failure did not set the flag");

  AST_LOCK_STICKY: assert property ( // RULE_17
    $past(lock_reg) != 3'h0 |-> (lock_reg & $past(lock_reg)) == $past(lock_reg))
    else $error("a lock bit cleared without reset");

  AST_BREAK_GATE: assert property ( // RULE_18
    !lock_reg[LOCK_CORE_STALL] && core_stall_in && !low_voltage_event && !parity_flag_reg
    |=> !timer_break)
    else $error("unlocked fault reached the timer break");

  AST_SELECT_FOLLOWS: assert property ( // RULE_19
    wr_en && paddr == OFS_SELECT_0_3 |=> select_reg[15:0] == $past(pwdata[15:0]) ##1
    event_lines[0] == $past(line_level[0]))
    else $error("selector write not applied on the next cycle");

  AST_IRQ_LEVEL: assert property (
    irq == $past(|(status_reg & mask_reg)))
    else $error("interrupt does not track masked status");

endmodule : system_config_routing_bank

// ===== sim/pin_source_model.sv
`timescale 1ns/100ps
module pin_source_model (
  // Port that drives all its pins high; the others stay low.
  input wire logic [1:0] hot_port,
  // Pin levels seen by the event line selection.
  output logic [15:0] port_a_pins,
  output logic [15:0] port_b_pins,
  output logic [15:0] port_c_pins,
  output logic [15:0] port_f_pins
);
  // One port high at a time, so each line reveals which port it follows.
  assign port_a_pins = (hot_port == 2'h0) ? 16'hffff : 16'h0000;
  assign port_b_pins = (hot_port == 2'h1) ? 16'hffff : 16'h0000;
  assign port_c_pins = (hot_port == 2'h2) ? 16'hffff : 16'h0000;
  assign port_f_pins = (hot_port == 2'h3) ? 16'hffff : 16'h0000;
endmodule : pin_source_model

// ===== sim/tb.sv
`timescale 1ns/100ps
module tb;
  import route_bank_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic boot_pin = 1'b1;
  logic boot_opt = 1'b0;
  logic high_drive_pin_enable;
  logic pin_pair_swap;
  logic [15:0] pa, pb, pc, pf, event_lines;
  logic [1:0] hot_port = 2'h0;
  logic [6:0] req = 7'h00;
  logic [4:0] dma_channel_req;
  logic par = 1'b0;
  logic lvd = 1'b0;
  logic stall = 1'b0;
  logic timer_break;
  logic irq;
  int n_errors = 0;
  int cmp_count = 0;
  logic [31:0] q;
  logic e;

  always #2 pclk = ~pclk;

  pin_source_model u_pin_source_model (.hot_port(hot_port), .port_a_pins(pa),
    .port_b_pins(pb), .port_c_pins(pc), .port_f_pins(pf));

  system_config_routing_bank u_system_config_routing_bank (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .boot_select_pin(boot_pin),
    .inverted_boot_option_bit(boot_opt), .high_drive_pin_enable(high_drive_pin_enable),
    .pin_pair_swap(pin_pair_swap), .port_a_pins(pa), .port_b_pins(pb), .port_c_pins(pc),
    .port_f_pins(pf), .event_lines(event_lines), .third_timer_ch1_req(req[0]),
    .third_timer_update_req(req[1]), .second_timer_ch1_req(req[2]),
    .second_timer_update_req(req[3]), .serial_rx_req(req[4]), .serial_tx_req(req[5]),
    .converter_req(req[6]), .dma_channel_req(dma_channel_req), .parity_error_in(par),
    .low_voltage_event(lvd), .core_stall_in(stall), .timer_break(timer_break), .irq(irq));

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
  endtask : do_reset

  // Setup cycle, then access held until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      $display("BAD pready expected 1 seen %b", pready);
      wrap_up();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check("read data", exp, q);
  endtask : rd

  task automatic t_reset();
    rd(OFS_BOOT_REMAP, 32'h0000_0003);
    rd(OFS_FAULT_LOCK, 32'h0000_0000);
    rd(OFS_SELECT_4_7, 32'h0000_0000);
    apb(1'b0, 12'h004, 32'h0000_0000);
    check("unmapped error", 32'h1, {31'h0, e});
    check("unmapped data", 32'h0, q);
    $display("test reset done");
  endtask : t_reset

  task automatic t_dma();
    int lo[7] = '{0, 0, 2, 2, 2, 1, 0};
    int hi[7] = '{1, 1, 3, 3, 4, 3, 1};
    for (int r = 0; r < 2; r++) begin
      apb(1'b1, OFS_BOOT_REMAP, r ? 32'hffff_ffff : 32'h0000_0000);
      rd(OFS_BOOT_REMAP, r ? 32'h0008_1f13 : 32'h0000_0003);
      check("high drive", r, high_drive_pin_enable);
      check("pin pair", r, pin_pair_swap);
      for (int j = 0; j < 7; j++) begin
        req <= 7'h01 << j;
        repeat (2) @(posedge pclk);
        check("channel", 32'h1 << (r ? hi[j] : lo[j]), dma_channel_req);
      end
      req <= 7'h00;
    end
    $display("test dma routing done");
  endtask : t_dma

  task automatic t_events();
    logic [15:0] exp[4] = '{16'h0904, 16'h8212, 16'h6000, 16'h00c1};
    apb(1'b1, OFS_SELECT_0_3, 32'hffff_5095);
    apb(1'b1, OFS_SELECT_4_7, 32'h0000_d521);
    apb(1'b1, OFS_SELECT_8_11, 32'h0000_8310);
    apb(1'b1, OFS_SELECT_12_15, 32'h0000_1a22);
    rd(OFS_SELECT_0_3, 32'h0000_5095);
    for (int p = 0; p < 4; p++) begin
      hot_port <= p[1:0];
      repeat (3) @(posedge pclk);
      check("event lines", exp[p], event_lines);
    end
    apb(1'b0, OFS_EVENT_STATUS, 32'h0000_0000);
    check("reserved status", 32'h8, q & 32'h8);
    $display("test event lines done");
  endtask : t_events

  task automatic t_fault();
    apb(1'b1, OFS_FAULT_LOCK, 32'h0000_0004);
    lvd <= 1'b1;
    repeat (3) @(posedge pclk);
    check("break low voltage", 1, timer_break);
    lvd <= 1'b0;
    apb(1'b1, OFS_FAULT_LOCK, 32'h0000_0000);
    rd(OFS_FAULT_LOCK, 32'h0000_0004);
    check("break idle", 0, timer_break);
    par <= 1'b1;
    @(posedge pclk);
    par <= 1'b0;
    repeat (2) @(posedge pclk);
    rd(OFS_FAULT_LOCK, 32'h0000_0104);
    check("break parity unlocked", 0, timer_break);
    apb(1'b1, OFS_FAULT_LOCK, 32'h0000_0002);
    repeat (2) @(posedge pclk);
    check("break parity", 1, timer_break);
    apb(1'b1, OFS_FAULT_LOCK, 32'h0000_0100);
    repeat (2) @(posedge pclk);
    rd(OFS_FAULT_LOCK, 32'h0000_0006);
    check("break cleared", 0, timer_break);
    apb(1'b1, OFS_FAULT_LOCK, 32'h0000_0001);
    stall <= 1'b1;
    repeat (3) @(posedge pclk);
    check("break stall", 1, timer_break);
    stall <= 1'b0;
    $display("test fault lock done");
  endtask : t_fault

  task automatic t_irq();
    apb(1'b1, OFS_EVENT_MASK, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    check("irq masked in", 1, irq);
    apb(1'b1, OFS_EVENT_STATUS, 32'h0000_000f);
    repeat (2) @(posedge pclk);
    check("irq cleared", 0, irq);
    rd(OFS_EVENT_STATUS, 32'h0000_0000);
    apb(1'b1, OFS_EVENT_MASK, 32'h0000_0000);
    lvd <= 1'b1;
    @(posedge pclk);
    lvd <= 1'b0;
    repeat (2) @(posedge pclk);
    check("irq masked out", 0, irq);
    apb(1'b1, OFS_EVENT_MASK, 32'h0000_0002);
    repeat (2) @(posedge pclk);
    check("irq unmasked", 1, irq);
    boot_pin <= 1'b0;
    do_reset();
    check("irq after reset", 0, irq);
    rd(OFS_FAULT_LOCK, 32'h0000_0000);
    rd(OFS_BOOT_REMAP, 32'h0000_0002);
    $display("test interrupt and reset done");
  endtask : t_irq

  initial begin
    do_reset();
    t_reset();
    t_dma();
    t_events();
    t_fault();
    t_irq();
    wrap_up();
  end
endmodule : tb
